// ### hdl/glp_pkg.sv
/*
 * Constants shared by the grid loss protection detector and its history
 * memory: widths, detector indices, counts and timing figures.
 * Assumes a single 40 MHz clock and measurement strobes from the front end.
 */
`default_nettype none

package glp_pkg;
	// ==========================================================
	// Widths and indices
	localparam int DW = 16;
	localparam int TW = 24;
	localparam int NDET = 6;
	localparam int NPH = 3;
	localparam int DET_SLOPE = 0;
	localparam int DET_JUMP = 1;
	localparam int DET_FREQ = 2;
	localparam int DET_VOLT = 3;
	localparam int DET_REV = 4;
	localparam int DET_NOPULSE = 5;
	// ==========================================================
	// Counts
	localparam int HIST_DEPTH = 5;
	localparam logic [2:0] CONSEC_PERIODS = 3'h4;
	localparam logic [3:0] REV_TRIP_SUM = 4'h8;
	// Gap in microseconds times frequency in centihertz for 2.5 periods.
	localparam logic [39:0] NOPULSE_PRODUCT = 40'h000EE6B280;
	// ==========================================================
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int VOLT_SAMPLE_MS = 500;
	localparam int VOLT_SAMPLE_CYC = CLK_HZ / 1000 * VOLT_SAMPLE_MS;
	localparam int US_CYC = CLK_HZ / 1_000_000;
	localparam int MS_US = 1000;
	// ==========================================================
	// Arming states
	typedef enum logic [1:0] {
		GLP_IDLE = 2'b00,
		GLP_BLANK = 2'b01,
		GLP_ARMED = 2'b10,
		GLP_TRIP = 2'b11
	} glp_state_t;
endpackage

`default_nettype wire

// ### hdl/glp_hist_mem.sv
/*
 * Five-deep history of measured grid cycle periods.
 * Assumes one write strobe per grid cycle; pair sums come out registered.
 */
`default_nettype none

module glp_hist_mem (
	input wire logic mclk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [glp_pkg::DW-1:0] din,
	output logic [glp_pkg::DW:0] new_sum,
	output logic [glp_pkg::DW:0] old_sum,
	output logic sum_stb
);
	logic [glp_pkg::DW-1:0] mem [glp_pkg::HIST_DEPTH];
	logic [2:0] fill;

	// ==========================================================
	// Shift store; slot 0 is the newest period.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem[0] <= '0;
		end else if (wr) begin
			mem[0] <= din;
		end
	end
	for (genvar i = 1; i < glp_pkg::HIST_DEPTH; i++) begin : g_shift
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				mem[i] <= '0;
			end else if (wr) begin
				mem[i] <= mem[i-1];
			end
		end
	end

	// Sums use the post-write view so the compare sees this cycle too.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			new_sum <= '0;
			old_sum <= '0;
			sum_stb <= 1'b0;
			fill <= 3'h0;
		end else begin
			sum_stb <= wr && (fill >= 3'h4);
			if (wr) begin
				new_sum <= {1'b0, din} + {1'b0, mem[0]};
				old_sum <= {1'b0, mem[2]} + {1'b0, mem[3]};
				if (fill < 3'h5) begin
					fill <= fill + 3'h1;
				end
			end
		end
	end
endmodule // glp_hist_mem

`default_nettype wire

// ### hdl/glp_detector.sv
/*
 * Grid loss protection detector: six detectors, blanking after contactor
 * closure, contactor release and warnings.
 * Assumes per-cycle measurements arrive with a one-cycle strobe, all
 * inputs synchronous to mclk. Frequencies are in centihertz, periods in us.
 */
`default_nettype none

module glp_detector #(
	parameter int VOLT_CYC = glp_pkg::VOLT_SAMPLE_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic period_stb,
	input wire logic [glp_pkg::DW-1:0] freq,
	input wire logic [glp_pkg::DW-1:0] period_us,
	input wire logic signed [glp_pkg::DW-1:0] pwr_export,
	input wire logic [glp_pkg::DW-1:0] volt_ph [glp_pkg::NPH],
	input wire logic freq_pulse,
	input wire logic par_mode,
	input wire logic contactor_cmd,
	input wire logic contactor_fb,
	input wire logic warn_clear,
	input wire logic [glp_pkg::DW-1:0] freq_slope_limit,
	input wire logic [glp_pkg::DW-1:0] jump_limit,
	input wire logic [glp_pkg::DW-1:0] freq_lo,
	input wire logic [glp_pkg::DW-1:0] freq_hi,
	input wire logic [glp_pkg::DW-1:0] volt_lo,
	input wire logic [glp_pkg::DW-1:0] volt_hi,
	input wire logic [glp_pkg::DW-1:0] rev_limit,
	input wire logic [glp_pkg::DW-1:0] blank_ms,
	output logic contactor_drive,
	output logic grid_loss_warn,
	output logic [glp_pkg::NDET-1:0] det_warn,
	output logic armed
);
	function automatic logic [glp_pkg::DW:0] abs_diff(
		input logic [glp_pkg::DW:0] a,
		input logic [glp_pkg::DW:0] b
	);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	glp_pkg::glp_state_t st;
	logic [glp_pkg::NDET-1:0] det_fail;
	logic fail_any;
	logic [glp_pkg::DW-1:0] freq_prev;
	logic have_prev;
	logic [2:0] slope_cnt;
	logic [2:0] win_cnt;
	logic slope_step;
	logic win_step;
	logic [glp_pkg::DW:0] new_sum;
	logic [glp_pkg::DW:0] old_sum;
	logic jump_stb;
	logic [31:0] volt_div;
	logic volt_tick;
	logic [glp_pkg::NPH-1:0] ph_bad;
	logic [3:0] rev_acc;
	logic [3:0] rev_w;
	logic [4:0] rev_sum;
	logic [5:0] us_div;
	logic us_tick;
	logic [9:0] ms_div;
	logic [glp_pkg::DW-1:0] blank_cnt;
	logic [glp_pkg::TW-1:0] gap_us;
	logic [39:0] gap_prod;
	logic signed [glp_pkg::DW+2:0] pwr_x;
	logic signed [glp_pkg::DW+2:0] lim_x;

	glp_hist_mem u_hist (
		.mclk(mclk),
		.rst(rst),
		.wr(period_stb),
		.din(period_us),
		.new_sum(new_sum),
		.old_sum(old_sum),
		.sum_stb(jump_stb)
	);

	// ==========================================================
	// Slope and frequency window run counters, one step per period.
	assign slope_step = have_prev && (abs_diff({1'b0, freq},
		{1'b0, freq_prev}) > {1'b0, freq_slope_limit});
	assign win_step = (freq < freq_lo) || (freq > freq_hi);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			freq_prev <= '0;
			have_prev <= 1'b0;
			slope_cnt <= 3'h0;
			win_cnt <= 3'h0;
		end else if (period_stb) begin
			freq_prev <= freq;
			have_prev <= 1'b1;
			// A quiet period restarts the run, so slow drift never trips.
			if (!slope_step) begin
				slope_cnt <= 3'h0;
			end else if (slope_cnt < glp_pkg::CONSEC_PERIODS) begin
				slope_cnt <= slope_cnt + 3'h1;
			end
			if (!win_step) begin
				win_cnt <= 3'h0;
			end else if (win_cnt < glp_pkg::CONSEC_PERIODS) begin
				win_cnt <= win_cnt + 3'h1;
			end
		end
	end

	// ==========================================================
	// Half-second voltage sampling enable.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			volt_div <= 32'h0;
			volt_tick <= 1'b0;
		end else begin
			volt_tick <= (volt_div == 32'(VOLT_CYC - 1));
			volt_div <= (volt_div == 32'(VOLT_CYC - 1)) ? 32'h0 :
				volt_div + 32'h1;
		end
	end
	for (genvar p = 0; p < glp_pkg::NPH; p++) begin : g_phase
		assign ph_bad[p] = (volt_ph[p] > volt_hi) ||
			(volt_ph[p] < volt_lo);
	end

	// ==========================================================
	// Reverse power weight: the larger the excess, the faster the trip.
	assign pwr_x = (glp_pkg::DW+3)'(pwr_export);
	assign lim_x = $signed({3'b000, rev_limit});
	always_comb begin
		if (pwr_x >= (lim_x <<< 3)) begin
			rev_w = 4'h8;
		end else if (pwr_x > (lim_x <<< 2)) begin
			rev_w = 4'h4;
		end else if (pwr_x > (lim_x <<< 1)) begin
			rev_w = 4'h2;
		end else if (pwr_x > lim_x) begin
			rev_w = 4'h1;
		end else begin
			rev_w = 4'h0;
		end
	end
	// One extra bit, so a saturated sum plus a full weight cannot wrap.
	assign rev_sum = {1'b0, rev_acc} + {1'b0, rev_w};
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rev_acc <= 4'h0;
		end else if (period_stb) begin
			if (rev_w == 4'h0) begin
				rev_acc <= 4'h0;
			end else if (rev_sum < {1'b0, glp_pkg::REV_TRIP_SUM}) begin
				rev_acc <= rev_sum[3:0];
			end else begin
				rev_acc <= glp_pkg::REV_TRIP_SUM;
			end
		end
	end

	// ==========================================================
	// Microsecond and millisecond enables for gap and blanking timers.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			us_div <= 6'h0;
			us_tick <= 1'b0;
			ms_div <= 10'h0;
		end else begin
			us_tick <= (us_div == 6'(glp_pkg::US_CYC - 1));
			us_div <= (us_div == 6'(glp_pkg::US_CYC - 1)) ? 6'h0 :
				us_div + 6'h1;
			// Restart outside blanking so the first millisecond is whole.
			if (st != glp_pkg::GLP_BLANK) begin
				ms_div <= 10'h0;
			end else if (us_tick) begin
				ms_div <= (ms_div == 10'(glp_pkg::MS_US - 1)) ? 10'h0 :
					ms_div + 10'h1;
			end
		end
	end
	// The gap saturates rather than wrapping, so a dead grid keeps failing.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gap_us <= '0;
		end else if (freq_pulse) begin
			gap_us <= '0;
		end else if (us_tick && gap_us != '1) begin
			gap_us <= gap_us + 24'h1;
		end
	end
	assign gap_prod = {16'h0, gap_us} * {24'h0, freq_lo};

	// ==========================================================
	// Detector outputs; a zero limit masks the slope, jump and reverse power detectors, and a zero freq_lo masks the missing pulse one.
	assign det_fail[glp_pkg::DET_SLOPE] = period_stb && slope_step &&
		(slope_cnt == glp_pkg::CONSEC_PERIODS - 3'h1) &&
		(freq_slope_limit != '0);
	assign det_fail[glp_pkg::DET_JUMP] = jump_stb && (jump_limit != '0) &&
		(abs_diff(new_sum, old_sum) > {jump_limit, 1'b0});
	assign det_fail[glp_pkg::DET_FREQ] = period_stb && win_step &&
		(win_cnt == glp_pkg::CONSEC_PERIODS - 3'h1);
	assign det_fail[glp_pkg::DET_VOLT] = volt_tick && (|ph_bad);
	assign det_fail[glp_pkg::DET_REV] = period_stb && (rev_limit != '0) &&
		(rev_w != 4'h0) &&
		(rev_sum >= {1'b0, glp_pkg::REV_TRIP_SUM});
	assign det_fail[glp_pkg::DET_NOPULSE] = (freq_lo != '0) &&
		(gap_prod >= glp_pkg::NOPULSE_PRODUCT);
	assign fail_any = |det_fail;

	// ==========================================================
	// Arming: blank after closure, then watch until a trip.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= glp_pkg::GLP_IDLE;
			blank_cnt <= '0;
		end else begin
			case (st)
				glp_pkg::GLP_IDLE: begin
					blank_cnt <= '0;
					if (par_mode && contactor_fb) begin
						st <= glp_pkg::GLP_BLANK;
					end
				end
				glp_pkg::GLP_BLANK: begin
					if (!(par_mode && contactor_fb)) begin
						st <= glp_pkg::GLP_IDLE;
					end else if (blank_cnt >= blank_ms) begin
						st <= glp_pkg::GLP_ARMED;
					end else if (us_tick &&
						ms_div == 10'(glp_pkg::MS_US - 1)) begin
						blank_cnt <= blank_cnt + 16'h1;
					end
				end
				glp_pkg::GLP_ARMED: begin
					if (fail_any) begin
						st <= glp_pkg::GLP_TRIP;
					end else if (!(par_mode && contactor_fb)) begin
						st <= glp_pkg::GLP_IDLE;
					end
				end
				glp_pkg::GLP_TRIP: begin
					if (warn_clear) begin
						st <= glp_pkg::GLP_IDLE;
					end
				end
				default: st <= glp_pkg::GLP_IDLE;
			endcase
		end
	end

	// Warnings latch; a new trip in the clear cycle still wins.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			grid_loss_warn <= 1'b0;
			det_warn <= '0;
			contactor_drive <= 1'b0;
			armed <= 1'b0;
		end else begin
			armed <= (st == glp_pkg::GLP_ARMED) && !fail_any;
			contactor_drive <= contactor_cmd && (st != glp_pkg::GLP_TRIP) &&
				!(st == glp_pkg::GLP_ARMED && fail_any);
			if (st == glp_pkg::GLP_ARMED && fail_any) begin
				grid_loss_warn <= 1'b1;
				det_warn <= det_warn | det_fail;
			end else if (warn_clear) begin
				grid_loss_warn <= 1'b0;
				det_warn <= '0;
			end
		end
	end

	// ==========================================================
	// Checks.
	sequence s_trip;
		(st == glp_pkg::GLP_ARMED) && fail_any;
	endsequence
	sequence s_released;
		!contactor_drive && grid_loss_warn;
	endsequence
	AST_CONTACTOR: assert property (@(posedge mclk) disable iff (rst)
		s_trip |=> s_released)
		else $error("Contactor not released on grid failure.");
	AST_WARN_ID: assert property (@(posedge mclk) disable iff (rst)
		s_trip |=> ((det_warn & $past(det_fail)) == $past(det_fail)))
		else $error("Detector warning missing.");
	AST_BLANK: assert property (@(posedge mclk) disable iff (rst)
		$rose(grid_loss_warn) |-> $past(st) == glp_pkg::GLP_ARMED)
		else $error("Warning raised while blanked.");
	AST_SLOPE: assert property (@(posedge mclk) disable iff (rst)
		det_fail[glp_pkg::DET_SLOPE] |=> slope_cnt == 3'h4)
		else $error("Slope trip without four periods.");
	AST_FREQ: assert property (@(posedge mclk) disable iff (rst)
		det_fail[glp_pkg::DET_FREQ] |=> win_cnt == 3'h4)
		else $error("Window trip without four periods.");
	AST_DISABLE: assert property (@(posedge mclk) disable iff (rst)
		(freq_slope_limit == '0) |-> !det_fail[glp_pkg::DET_SLOPE] &&
		((rev_limit == '0) -> !det_fail[glp_pkg::DET_REV]))
		else $error("Disabled detector reported.");
	AST_VOLT: assert property (@(posedge mclk) disable iff (rst)
		det_fail[glp_pkg::DET_VOLT] |-> $past(volt_div) == VOLT_CYC - 1)
		else $error("Voltage check off the sample tick.");
	AST_REV_SLOW: assert property (@(posedge mclk) disable iff (rst)
		det_fail[glp_pkg::DET_REV] && rev_w == 4'h1 |-> rev_acc >= 4'h7)
		else $error("Small reverse power tripped early.");
	AST_NOPULSE: assert property (@(posedge mclk) disable iff (rst)
		freq_pulse |=> !det_fail[glp_pkg::DET_NOPULSE])
		else $error("Missing pulse flagged after a pulse.");
	AST_JUMP: assert property (@(posedge mclk) disable iff (rst)
		det_fail[glp_pkg::DET_JUMP] |-> $past(period_stb))
		else $error("Phase jump outside a cycle end.");
endmodule // glp_detector

`default_nettype wire

// ### bench/glp_front_model.sv
/*
 * Model of the grid measurement front end and the grid contactor.
 * Assumes the bench calls grid_cycle once per simulated grid cycle.
 */
`default_nettype none

module glp_front_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic contactor_drive,
	output logic period_stb,
	output logic [glp_pkg::DW-1:0] freq,
	output logic [glp_pkg::DW-1:0] period_us,
	output logic signed [glp_pkg::DW-1:0] pwr_export,
	output logic freq_pulse,
	output wire logic contactor_fb
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] pole;

	// ==========================================================
	// Contactor
	// The contacts follow the coil three clocks late, like a slow relay.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pole <= 3'h0;
		end else begin
			pole <= {pole[1:0], contactor_drive};
		end
	end
	assign contactor_fb = pole[2];

	// ==========================================================
	// Measurements
	// Values are valid only with the strobe; between strobes the lines show
	// the inverse so that a late sample cannot match by accident.
	initial begin
		period_stb = 1'b0;
		freq_pulse = 1'b0;
		freq = 16'h0000;
		period_us = 16'h0000;
		pwr_export = 16'sh0000;
	end

	task automatic grid_cycle(input logic [glp_pkg::DW-1:0] f,
		input logic [glp_pkg::DW-1:0] p, input logic signed [15:0] w);
		@(posedge mclk);
		#2;
		period_stb = 1'b1;
		freq_pulse = 1'b1;
		freq = f;
		period_us = p;
		pwr_export = w;
		@(posedge mclk);
		#2;
		period_stb = 1'b0;
		freq_pulse = 1'b0;
		freq = ~f;
		period_us = ~p;
		pwr_export = ~w;
		repeat (36) @(posedge mclk);
	endtask
endmodule // glp_front_model

`default_nettype wire

// ### bench/glp_detector_test.sv
/*
 * Self-checking bench for the grid loss protection detector.
 * Assumes glp_pkg is compiled first and the front end model beside it.
 */
`default_nettype none

module glp_detector_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int VC = 100;
	localparam logic [15:0] NF = 16'hF230;
	localparam logic [15:0] NP = 16'h4E20;
	localparam logic [15:0] VN = 16'h00E6;
	logic mclk, rst, par_mode, contactor_cmd, warn_clear;
	logic [glp_pkg::DW-1:0] s_lim, j_lim, f_lo, f_hi, v_lo, v_hi, r_lim, blank;
	logic [glp_pkg::DW-1:0] volt [glp_pkg::NPH];
	wire logic stb, pulse, fb, drive, gwarn, armed;
	wire logic [glp_pkg::DW-1:0] freq, period_us;
	wire logic signed [glp_pkg::DW-1:0] pwr;
	wire logic [glp_pkg::NDET-1:0] det_warn;
	int n_fail = 0;
	int n_compared = 0;
	int seed = 22811;
	int i, s, ph;
	logic [15:0] d;

	glp_front_model i_fe (.mclk(mclk), .rst(rst), .contactor_drive(drive),
		.period_stb(stb), .freq(freq), .period_us(period_us),
		.pwr_export(pwr), .freq_pulse(pulse), .contactor_fb(fb));

	glp_detector #(.VOLT_CYC(VC)) i_dut (.mclk(mclk), .rst(rst),
		.period_stb(stb), .freq(freq), .period_us(period_us),
		.pwr_export(pwr), .volt_ph(volt), .freq_pulse(pulse),
		.par_mode(par_mode), .contactor_cmd(contactor_cmd),
		.contactor_fb(fb), .warn_clear(warn_clear),
		.freq_slope_limit(s_lim), .jump_limit(j_lim), .freq_lo(f_lo),
		.freq_hi(f_hi), .volt_lo(v_lo), .volt_hi(v_hi), .rev_limit(r_lim),
		.blank_ms(blank), .contactor_drive(drive), .grid_loss_warn(gwarn),
		.det_warn(det_warn), .armed(armed));

	// ==========================================================
	// Clock and helpers
	// A 25 ns period gives the 40 MHz system clock.
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic wrap_up();
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [5:0] exp,
		input logic [5:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// Compares the trip outputs against the mask of detectors that fired.
	task automatic outcome(input logic [5:0] m);
		chk("det_warn", m, det_warn);
		chk("grid_loss_warn", {5'h0, |m}, {5'h0, gwarn});
		chk("contactor_drive", {5'h0, ~|m}, {5'h0, drive});
	endtask

	// Bounded wait for the arming; the first one spans a whole blanking time.
	task automatic wait_armed();
		for (i = 0; i < 60000 && armed !== 1'b1; i++) @(posedge mclk);
		if (armed !== 1'b1) begin
			n_fail++;
			wrap_up();
		end
	endtask

	// Refills the period history with calm data while still tripped, so
	// stale periods cannot trip the fresh arming; then clears and rearms.
	task automatic rearm();
		repeat (6) i_fe.grid_cycle(NF, NP, 16'sh0000);
		@(posedge mclk);
		#2;
		warn_clear = 1'b1;
		@(posedge mclk);
		#2;
		warn_clear = 1'b0;
		wait_armed();
	endtask

	// Sends n cycles, checking after each; alt returns to nominal on evens.
	task automatic burst(input int n, input logic [15:0] f,
		input logic [15:0] p, input logic signed [15:0] w, input logic alt,
		input logic [5:0] m);
		int k;
		for (k = 1; k <= n; k++) begin
			i_fe.grid_cycle((alt && !k[0]) ? NF : f, p, w);
			outcome(k == n ? m : 6'h00);
		end
		if (m != 6'h00) begin
			rearm();
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		par_mode = 1'b0;
		contactor_cmd = 1'b0;
		warn_clear = 1'b0;
		{s_lim, j_lim, f_lo, f_hi} = {16'h01F4, 16'h012C, 16'hEA60, 16'hFDE8};
		{v_lo, v_hi, r_lim, blank} = {16'h00C8, 16'h0104, 16'h03E8, 16'h0001};
		volt = '{VN, VN, VN};
		repeat (5) @(posedge mclk);
		#2;
		chk("idle outputs", 6'h00, {3'h0, drive, gwarn, armed});
		chk("idle det_warn", 6'h00, det_warn);
		rst = 1'b0;
		par_mode = 1'b1;
		contactor_cmd = 1'b1;
		repeat (10) @(posedge mclk);
		#2;
		chk("armed", 6'h00, {5'h0, armed});
		burst(5, NF + 16'h0BB8, NP, 16'sh7000, 1'b1, 6'h00);
		wait_armed();
		blank = 16'h0000;
		// Slow drift must not look like a fault.
		for (s = 0; s < 8; s++) i_fe.grid_cycle(NF + 16'(100 * s), NP, 16'sh0);
		outcome(6'h00);
		repeat (6) i_fe.grid_cycle(NF, NP, 16'sh0000);
		d = 16'(600 + $unsigned($random(seed)) % 1000);
		burst(4, NF + d, NP, 16'sh0000, 1'b1, 6'h01);
		burst(4, f_hi + 16'h0001, NP, 16'sh0000, 1'b0, 6'h04);
		burst(4, f_lo - 16'h0001, NP, 16'sh0000, 1'b0, 6'h04);
		d = 16'(301 + $unsigned($random(seed)) % 299);
		burst(2, NF, NP + d, 16'sh0000, 1'b0, 6'h02);
		burst(6, NF, NP, 16'sh03E8, 1'b0, 6'h00);
		burst(8, NF, NP, 16'sh07D0, 1'b0, 6'h10);
		d = 16'(2001 + $unsigned($random(seed)) % 1999);
		burst(4, NF, NP, signed'(d), 1'b0, 6'h10);
		burst(1, NF, NP, 16'sh1F40, 1'b0, 6'h10);
		// Both voltage limits on a randomly chosen phase.
		for (s = 0; s < 2; s++) begin
			ph = $unsigned($random(seed)) % 3;
			@(posedge mclk);
			#2;
			volt[ph] = (s == 0) ? v_hi + 16'h0001 : v_lo - 16'h0001;
			for (i = 0; i < 2 * VC && gwarn !== 1'b1; i++) @(posedge mclk);
			#2;
			outcome(6'h08);
			volt[ph] = VN;
			rearm();
		end
		// Zero limits switch those detectors off entirely.
		{s_lim, r_lim, j_lim} = {16'h0000, 16'h0000, 16'h0000};
		burst(4, NF + 16'h0BB8, NP, 16'sh0000, 1'b1, 6'h00);
		burst(8, NF, NP, 16'sh7000, 1'b0, 6'h00);
		burst(2, NF, NP + 16'h0190, 16'sh0000, 1'b0, 6'h00);
		wrap_up();
	end
endmodule // glp_detector_test

`default_nettype wire
